// [hw/sec_pkg.sv]
package sec_pkg;
  // opcodes
  localparam logic [7:0] OP_TMS_RISE = 8'h4a;
  localparam logic [7:0] OP_TMS_FALL = 8'h4b;
  localparam logic [7:0] OP_TMSR_RR  = 8'h6a;
  localparam logic [7:0] OP_TMSR_FR  = 8'h6b;
  localparam logic [7:0] OP_TMSR_RF  = 8'h6e;
  localparam logic [7:0] OP_TMSR_FF  = 8'h6f;
  localparam logic [7:0] OP_SET_LOW  = 8'h80;
  localparam logic [7:0] OP_GET_LOW  = 8'h81;
  localparam logic [7:0] OP_SET_HIGH = 8'h82;
  localparam logic [7:0] OP_GET_HIGH = 8'h83;
  localparam logic [7:0] OP_LOOP_ON  = 8'h84;
  localparam logic [7:0] OP_LOOP_OFF = 8'h85;
  localparam logic [7:0] OP_SET_DIV  = 8'h86;
  localparam logic [7:0] OP_FLUSH    = 8'h87;
  localparam logic [7:0] OP_WAIT_HI  = 8'h88;
  localparam logic [7:0] OP_WAIT_LO  = 8'h89;
  localparam logic [7:0] OP_BUS_RS   = 8'h90;
  localparam logic [7:0] OP_BUS_RE   = 8'h91;
  localparam logic [7:0] OP_BUS_WS   = 8'h92;
  localparam logic [7:0] OP_BUS_WE   = 8'h93;
  // opcode bit meanings
  localparam int OPB_CHG_FALL = 0;
  localparam int OPB_EXT      = 0;
  localparam int OPB_WRITE    = 1;
  localparam int OPB_SMP_FALL = 2;
  localparam int OPB_READ     = 5;
  // low group pin positions
  localparam int PIN_CLK  = 0;
  localparam int PIN_DOUT = 1;
  localparam int PIN_DIN  = 2;
  localparam int PIN_TMS  = 3;
  localparam int PIN_WAIT = 5;
  // reset values and timing
  localparam logic [7:0]  PINS_RST = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0000;
  localparam logic [2:0]  PRE_LAST = 3'h4; // divide-by-5 front stage
  localparam int CLK_PERIOD_NS = 8;
  localparam int BUS_STEP_NS   = 40;
  localparam logic [3:0] BUS_STEP_LAST =
    4'((BUS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ARGS   = 3'b001,
    ST_EXEC   = 3'b010,
    ST_SHIFT  = 3'b011,
    ST_BUS    = 3'b100,
    ST_WAIT   = 3'b101,
    ST_REPLY  = 3'b110
  } sec_state_t;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] dir;
  } sec_pins_t;

  typedef struct packed {
    logic cs_n;
    logic ale;
    logic wr_n;
    logic rd_n;
  } sec_strobe_t;

  localparam sec_strobe_t STROBE_IDLE = 4'hb;
endpackage

// [hw/sec_engine.sv]
`timescale 1ns/10ps
module sec_engine
  import sec_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       controller_enable,
  input  wire logic       div5_enable,
  input  wire logic       cpu_mode,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  output logic [7:0]      rsp_data,
  output logic            rsp_valid,
  input  wire logic       rsp_ready,
  output logic            rsp_flush,
  input  wire logic [7:0] low_pin_group_in,
  output logic [7:0]      low_pin_group_out,
  output logic [7:0]      low_pin_group_oe_n,
  input  wire logic [7:0] high_pin_group_in,
  output logic [7:0]      high_pin_group_out,
  output logic [7:0]      high_pin_group_oe_n,
  input  wire logic [7:0] cpu_ad_in,
  output logic [7:0]      cpu_ad_out,
  output logic [7:0]      cpu_ad_oe_n,
  output logic [7:0]      cpu_addr_high,
  output sec_strobe_t     cpu_strobe,
  input  wire logic [1:0] cpu_aux_in
);

  // operand count per opcode
  function automatic logic [1:0] arg_need(input logic [7:0] op);
    logic [1:0] n;
    n = 2'h0;
    if (op == OP_SET_LOW || op == OP_SET_HIGH || op == OP_SET_DIV ||
        op == OP_BUS_RE || op == OP_BUS_WS)
      n = 2'h2;
    else if (op == OP_TMS_RISE || op == OP_TMS_FALL ||
             op == OP_TMSR_RR || op == OP_TMSR_FR ||
             op == OP_TMSR_RF || op == OP_TMSR_FF)
      n = 2'h2;
    else if (op == OP_BUS_RS)
      n = 2'h1;
    else if (op == OP_BUS_WE)
      n = 2'h3;
    return n;
  endfunction

  sec_state_t  state, next_state;
  logic [7:0]  opcode, next_opcode;
  logic [7:0]  args [3];
  logic [7:0]  next_args [3];
  logic [1:0]  arg_cnt, next_arg_cnt;
  sec_pins_t   low, next_low;
  sec_pins_t   high, next_high;
  logic [15:0] div, next_div;
  logic        loop_en, next_loop_en;
  logic [2:0]  pre_cnt, next_pre_cnt;
  logic [15:0] half_cnt, next_half_cnt;
  logic        phase, next_phase;
  logic [3:0]  bit_cnt, next_bit_cnt;
  logic [7:0]  tms_shift, next_tms_shift;
  logic [7:0]  rd_shift, next_rd_shift;
  logic [7:0]  reply, next_reply;
  logic [1:0]  bus_step, next_bus_step;
  logic [3:0]  step_cnt, next_step_cnt;
  sec_strobe_t strobe, next_strobe;
  logic [7:0]  ad_out, next_ad_out;
  logic        ad_drive, next_ad_drive;
  logic [7:0]  addr_hi, next_addr_hi;
  logic        flush, next_flush;
  // reply buffer
  logic [7:0]  buf_mem [2];
  logic        wr_ptr, rd_ptr;
  logic [1:0]  buf_cnt, next_buf_cnt;
  logic        buf_in_ready, push, pop;
  // combinational helpers
  logic        tick, half_end, rising, din, wait_line;

  assign cmd_ready = controller_enable &&
                     (state == ST_OPCODE || state == ST_ARGS);
  assign din = loop_en ? low.value[PIN_DOUT]
                       : low_pin_group_in[PIN_DIN];
  assign wait_line = cpu_mode ? cpu_aux_in[0]
                              : low_pin_group_in[PIN_WAIT];
  assign tick = !div5_enable || pre_cnt == PRE_LAST;
  assign half_end = tick && half_cnt == div;
  assign rising = !low.value[PIN_CLK];

  // command sequencer next values
  always_comb begin
    next_state     = state;
    next_opcode    = opcode;
    next_args      = args;
    next_arg_cnt   = arg_cnt;
    next_low       = low;
    next_high      = high;
    next_div       = div;
    next_loop_en   = loop_en;
    next_pre_cnt   = pre_cnt;
    next_half_cnt  = half_cnt;
    next_phase     = phase;
    next_bit_cnt   = bit_cnt;
    next_tms_shift = tms_shift;
    next_rd_shift  = rd_shift;
    next_reply     = reply;
    next_bus_step  = bus_step;
    next_step_cnt  = step_cnt;
    next_strobe    = strobe;
    next_ad_out    = ad_out;
    next_ad_drive  = ad_drive;
    next_addr_hi   = addr_hi;
    next_flush     = 1'b0;
    case (state)
      ST_OPCODE: begin
        if (cmd_valid && controller_enable) begin
          next_opcode  = cmd_data;
          next_arg_cnt = 2'h0;
          next_state   = arg_need(cmd_data) == 2'h0 ? ST_EXEC
                                                    : ST_ARGS;
        end
      end
      ST_ARGS: begin
        if (cmd_valid && controller_enable) begin
          next_args[arg_cnt] = cmd_data;
          next_arg_cnt = arg_cnt + 2'h1;
          if (arg_cnt + 2'h1 == arg_need(opcode))
            next_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        next_state = ST_OPCODE;
        if (opcode == OP_SET_LOW) begin
          next_low = {args[0], args[1]};
        end else if (opcode == OP_SET_HIGH) begin
          next_high = {args[0], args[1]};
        end else if (opcode == OP_GET_LOW) begin
          next_reply = low_pin_group_in;
          next_state = ST_REPLY;
        end else if (opcode == OP_GET_HIGH) begin
          next_reply = high_pin_group_in;
          next_state = ST_REPLY;
        end else if (opcode == OP_LOOP_ON) begin
          next_loop_en = 1'b1;
        end else if (opcode == OP_LOOP_OFF) begin
          next_loop_en = 1'b0;
        end else if (opcode == OP_SET_DIV) begin
          next_div = {args[1], args[0]};
        end else if (opcode == OP_FLUSH) begin
          next_flush = 1'b1;
        end else if (opcode == OP_WAIT_HI || opcode == OP_WAIT_LO) begin
          next_state = ST_WAIT;
        end else if (arg_need(opcode) == 2'h2 &&
                     opcode[3:0] inside {4'ha, 4'hb, 4'he, 4'hf}) begin
          // data bit 7 and first tms bit go out before any clock
          next_low.value[PIN_DOUT] = args[1][7];
          next_low.value[PIN_TMS]  = args[1][0];
          next_tms_shift = {1'b0, args[1][7:1]};
          next_rd_shift  = 8'h00;
          next_bit_cnt   = 4'h0;
          next_phase     = 1'b0;
          next_pre_cnt   = 3'h0;
          next_half_cnt  = 16'h0000;
          next_state     = ST_SHIFT;
        end else if (opcode[7:2] == OP_BUS_RS[7:2]) begin
          // address phase: cs low, ale high, low address on bus
          next_addr_hi  = opcode[OPB_EXT] ? args[0] : 8'h00;
          next_ad_out   = opcode[OPB_EXT] ? args[1] : args[0];
          next_ad_drive = 1'b1;
          next_strobe   = '{cs_n: 1'b0, ale: 1'b1,
                            wr_n: 1'b1, rd_n: 1'b1};
          next_bus_step = 2'h0;
          next_step_cnt = 4'h0;
          next_state    = ST_BUS;
        end
      end
      ST_SHIFT: begin
        next_pre_cnt  = (!div5_enable || tick) ? 3'h0
                                               : pre_cnt + 3'h1;
        next_half_cnt = half_end ? 16'h0000
                      : tick ? half_cnt + 16'h0001 : half_cnt;
        if (half_end) begin
          // toggle: two equal halves per bit
          next_low.value[PIN_CLK] = rising;
          next_phase = !phase;
          if (opcode[OPB_READ] && rising != opcode[OPB_SMP_FALL])
            next_rd_shift = {din, rd_shift[7:1]};
          if (rising != opcode[OPB_CHG_FALL] &&
              bit_cnt < {1'b0, args[0][2:0]}) begin
            next_low.value[PIN_TMS] = tms_shift[0];
            next_tms_shift = {1'b0, tms_shift[7:1]};
          end
          if (phase) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == {1'b0, args[0][2:0]}) begin
              next_reply = next_rd_shift;
              next_state = opcode[OPB_READ] ? ST_REPLY
                                            : ST_OPCODE;
            end
          end
        end
      end
      ST_BUS: begin
        next_step_cnt = step_cnt + 4'h1;
        if (step_cnt == BUS_STEP_LAST) begin
          next_step_cnt = 4'h0;
          next_bus_step = bus_step + 2'h1;
          case (bus_step)
            2'h0: begin
              next_strobe.ale = 1'b0;
            end
            2'h1: begin
              if (opcode[OPB_WRITE]) begin
                next_ad_out = opcode[OPB_EXT] ? args[2]
                                              : args[1];
                next_strobe.wr_n = 1'b0;
              end else begin
                next_ad_drive = 1'b0;
                next_strobe.rd_n = 1'b0;
              end
            end
            2'h2: begin
              if (!opcode[OPB_WRITE])
                next_reply = cpu_ad_in;
              next_strobe.wr_n = 1'b1;
              next_strobe.rd_n = 1'b1;
            end
            default: begin
              next_strobe   = STROBE_IDLE;
              next_ad_drive = 1'b0;
              next_state = opcode[OPB_WRITE] ? ST_OPCODE
                                             : ST_REPLY;
            end
          endcase
        end
      end
      ST_WAIT: begin
        if (wait_line == !opcode[0])
          next_state = ST_OPCODE;
      end
      ST_REPLY: begin
        if (buf_in_ready)
          next_state = ST_OPCODE;
      end
      default: begin
        next_state = ST_OPCODE;
      end
    endcase
    // disabling the controller exits any command, stalled or not, back to the opcode fetch state
    if (!controller_enable) begin
      next_state  = ST_OPCODE;
      next_strobe = STROBE_IDLE;
      next_ad_drive = 1'b0;
      next_low.value[PIN_CLK] = state == ST_SHIFT
        ? (phase ? rising : low.value[PIN_CLK]) : low.value[PIN_CLK];
    end
  end

  // command sequencer registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state     <= ST_OPCODE;
      opcode    <= 8'h00;
      args      <= '{8'h00, 8'h00, 8'h00};
      arg_cnt   <= 2'h0;
      low       <= {PINS_RST, PINS_RST};
      high      <= {PINS_RST, PINS_RST};
      div       <= DIV_RST;
      loop_en   <= 1'b0;
      pre_cnt   <= 3'h0;
      half_cnt  <= 16'h0000;
      phase     <= 1'b0;
      bit_cnt   <= 4'h0;
      tms_shift <= 8'h00;
      rd_shift  <= 8'h00;
      reply     <= 8'h00;
      bus_step  <= 2'h0;
      step_cnt  <= 4'h0;
      strobe    <= STROBE_IDLE;
      ad_out    <= 8'h00;
      ad_drive  <= 1'b0;
      addr_hi   <= 8'h00;
      flush     <= 1'b0;
    end else begin
      state     <= next_state;
      opcode    <= next_opcode;
      args      <= next_args;
      arg_cnt   <= next_arg_cnt;
      low       <= next_low;
      high      <= next_high;
      div       <= next_div;
      loop_en   <= next_loop_en;
      pre_cnt   <= next_pre_cnt;
      half_cnt  <= next_half_cnt;
      phase     <= next_phase;
      bit_cnt   <= next_bit_cnt;
      tms_shift <= next_tms_shift;
      rd_shift  <= next_rd_shift;
      reply     <= next_reply;
      bus_step  <= next_bus_step;
      step_cnt  <= next_step_cnt;
      strobe    <= next_strobe;
      ad_out    <= next_ad_out;
      ad_drive  <= next_ad_drive;
      addr_hi   <= next_addr_hi;
      flush     <= next_flush;
    end
  end

  // two-entry reply buffer, sequencer stalls in reply state when full
  assign buf_in_ready = buf_cnt != 2'h2;
  assign push = state == ST_REPLY && buf_in_ready;
  assign pop  = rsp_valid && rsp_ready;
  assign rsp_valid = buf_cnt != 2'h0;
  assign rsp_data  = buf_mem[rd_ptr];

  always_comb begin
    next_buf_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      buf_mem <= '{8'h00, 8'h00};
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (push)
        buf_mem[wr_ptr] <= reply;
      wr_ptr  <= wr_ptr ^ push;
      rd_ptr  <= rd_ptr ^ pop;
      buf_cnt <= next_buf_cnt;
    end
  end

  // pin and bus outputs, all from registers
  assign low_pin_group_out   = low.value;
  assign low_pin_group_oe_n  = ~low.dir;
  assign high_pin_group_out  = high.value;
  assign high_pin_group_oe_n = ~high.dir;
  assign cpu_ad_out    = ad_out;
  assign cpu_ad_oe_n   = {8{!ad_drive}};
  assign cpu_addr_high = addr_hi;
  assign cpu_strobe    = strobe;
  assign rsp_flush     = flush;

endmodule

// [tb/sec_target_model.sv]
`timescale 1ns/10ps
module sec_target_model
  import sec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [7:0]  low_out,
  input  wire logic [7:0]  low_oe_n,
  input  wire logic [7:0]  low_drive,
  output logic [7:0]       low_in,
  input  wire logic [7:0]  high_out,
  input  wire logic [7:0]  high_oe_n,
  input  wire logic [7:0]  high_drive,
  output logic [7:0]       high_in,
  input  wire logic [7:0]  ad_out,
  input  wire logic [7:0]  ad_oe_n,
  input  wire logic [7:0]  addr_high,
  input  wire sec_strobe_t strobe,
  output logic [7:0]       ad_in
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr;
  logic [7:0]  flip = 8'h5a;

  // pin level from whichever side drives it
  assign low_in = (low_oe_n & low_drive) | (~low_oe_n & low_out);
  assign high_in = (high_oe_n & high_drive) | (~high_oe_n & high_out);

  // address latch and write capture
  always @(posedge clock) begin
    flip <= ~flip;
    if (strobe.ale && !strobe.cs_n)
      addr <= {addr_high, ad_out};
    if (!strobe.wr_n && !strobe.cs_n)
      mem[addr] <= ad_out;
  end

  // read data only while strobed, else the engine's driven value, or a changing pattern while the bus floats
  assign ad_in = !strobe.rd_n ? mem[addr] :
                 (ad_oe_n == 8'h00 ? ad_out : flip);
endmodule

// [tb/sec_engine_checker.sv]
`timescale 1ns/10ps
module sec_engine_checker
  import sec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        controller_enable,
  input  wire logic        cmd_ready,
  input  wire logic [7:0]  rsp_data,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_ready,
  input  wire logic        rsp_flush,
  input  wire logic [7:0]  low_pin_group_out,
  input  wire logic [7:0]  cpu_ad_oe_n,
  input  wire sec_strobe_t cpu_strobe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // bus strobe sequence
  property p_cs_ale;
    $fell(cpu_strobe.cs_n) |-> cpu_strobe.ale;
  endproperty
  a_cs_ale: assert property (p_cs_ale) else $error("ale missing");
  property p_ale_len;
    $rose(cpu_strobe.ale) |-> cpu_strobe.ale[*5] ##1 !cpu_strobe.ale;
  endproperty
  a_ale_len: assert property (p_ale_len) else $error("ale width");
  property p_wr_drive;
    !cpu_strobe.wr_n |-> cpu_ad_oe_n == 8'h00 && !cpu_strobe.cs_n;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("wr bus");
  property p_rd_float;
    !cpu_strobe.rd_n |-> cpu_ad_oe_n == 8'hff && !cpu_strobe.cs_n;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("rd bus");
  property p_rd_len;
    $fell(cpu_strobe.rd_n) |-> (!cpu_strobe.rd_n)[*5] ##1 cpu_strobe.rd_n;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("rd width");

  // command flow and replies
  // disabling ends any command: fetch state, strobes idle, bus released
  property p_ready_en;
    !controller_enable |=> cmd_ready == controller_enable &&
      cpu_strobe == STROBE_IDLE && cpu_ad_oe_n == 8'hff;
  endproperty
  a_ready_en: assert property (p_ready_en) else $error("ready");
  property p_flush;
    rsp_flush |=> !rsp_flush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush width");
  property p_rsp_hold;
    rsp_valid && !rsp_ready && controller_enable |=>
      rsp_valid && $stable(rsp_data);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("reply");
  property p_dout_hold;
    !cmd_ready && !$past(cmd_ready) && $changed(low_pin_group_out[PIN_CLK])
      |-> $stable(low_pin_group_out[PIN_DOUT]);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("dout");

  c_wr: cover property ($fell(cpu_strobe.wr_n));
  c_rd: cover property ($fell(cpu_strobe.rd_n));
  c_flush: cover property (rsp_flush);
endmodule

bind sec_engine sec_engine_checker u_chk (
  .clock(clock), .nrst(nrst), .controller_enable(controller_enable),
  .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready), .rsp_flush(rsp_flush),
  .low_pin_group_out(low_pin_group_out), .cpu_ad_oe_n(cpu_ad_oe_n),
  .cpu_strobe(cpu_strobe));

// [tb/tb_sec_engine.sv]
`timescale 1ns/10ps
module tb_sec_engine
  import sec_pkg::*;
();
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        en = 1'b1;
  logic        div5 = 1'b0;
  logic        cpu_mode = 1'b0;
  logic [7:0]  cmd_data = 8'h00;
  logic        cmd_valid = 1'b0;
  logic        rsp_ready = 1'b1;
  logic [7:0]  low_drive = 8'h00;
  logic [7:0]  high_drive = 8'h00;
  logic [1:0]  aux = 2'h0;
  logic        cmd_ready, rsp_valid, rsp_flush, prev_clk, idle;
  logic [7:0]  rsp_data, low_in, low_out, low_oe_n, high_in, high_out;
  logic [7:0]  high_oe_n, ad_in, ad_out, ad_oe_n, addr_high;
  logic [7:0]  d, v, m, ln, a, h, w, tms_seq;
  sec_strobe_t strobe;
  logic [31:0] seed = 32'hc1d0;
  logic [7:0]  exp_q[$], msk_q[$];
  logic [7:0]  ops[6] = '{OP_TMS_FALL, OP_TMSR_FR, OP_TMSR_FF,
                          OP_TMS_RISE, OP_TMSR_RR, OP_TMSR_RF};
  int          err_count = 0, tests_run = 0, flushes = 0;
  int          nonidle = 0, nbits = 0;

  always #4 clock = ~clock;

  sec_engine uut (.clock(clock), .nrst(nrst), .controller_enable(en),
    .div5_enable(div5), .cpu_mode(cpu_mode), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_flush(rsp_flush),
    .low_pin_group_in(low_in), .low_pin_group_out(low_out),
    .low_pin_group_oe_n(low_oe_n), .high_pin_group_in(high_in),
    .high_pin_group_out(high_out), .high_pin_group_oe_n(high_oe_n),
    .cpu_ad_in(ad_in), .cpu_ad_out(ad_out), .cpu_ad_oe_n(ad_oe_n),
    .cpu_addr_high(addr_high), .cpu_strobe(strobe), .cpu_aux_in(aux));

  sec_target_model u_tgt (.clock(clock), .low_out(low_out),
    .low_oe_n(low_oe_n), .low_drive(low_drive), .low_in(low_in),
    .high_out(high_out), .high_oe_n(high_oe_n), .high_drive(high_drive),
    .high_in(high_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
    .addr_high(addr_high), .strobe(strobe), .ad_in(ad_in));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic summarize();
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic want(input logic [7:0] e, input logic [7:0] mk);
    exp_q.push_back(e & mk);
    msk_q.push_back(mk);
  endtask

  // bytes offered back to back, valid dropped after the last
  task automatic cmd(input logic [7:0] b[$]);
    int n;
    foreach (b[i]) begin
      cmd_data = b[i];
      cmd_valid = 1'b1;
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (cmd_ready !== 1'b1 && n < 3000);
      #1;
      if (n >= 3000) begin
        err_count++;
        summarize();
      end
    end
    cmd_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask

  // wait until idle and all replies drained
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while ((cmd_ready !== 1'b1 || exp_q.size() != 0) && n < 3000);
    #1;
    if (n >= 3000) begin
      err_count++;
      summarize();
    end
  endtask

  // reply compare and shift clock watch
  always @(posedge clock) begin
    prev_clk <= low_out[PIN_CLK];
    if (rsp_flush === 1'b1) flushes++;
    if (low_out[PIN_CLK] !== idle) nonidle++;
    if (low_out[PIN_CLK] !== idle && prev_clk === idle) begin
      tms_seq = {low_out[PIN_TMS], tms_seq[7:1]};
      nbits++;
      chk8("serial out", {7'h00, d[7]}, {7'h00, low_out[PIN_DOUT]});
    end
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (exp_q.size() == 0) chk8("reply count", 8'h00, 8'h01);
      else chk8("reply", exp_q.pop_front(), rsp_data & msk_q.pop_front());
    end
  end

  initial begin
    idle = 1'b0;
    d = 8'h00;
    repeat (10) @(posedge clock);
    #1;
    nrst = 1'b1;
    chk8("reset oe_n", 8'hff, low_oe_n);
    cmd('{OP_SET_LOW, 8'h08, 8'h0b});
    settle();
    chk8("low out", 8'h08, low_out & 8'h0b);
    chk8("low oe_n", 8'hf4, low_oe_n);
    v = rnd();
    m = rnd();
    cmd('{OP_SET_HIGH, v, m});
    settle();
    chk8("high out", v & m, high_out & m);
    chk8("high oe_n", ~m, high_oe_n);
    low_drive = rnd() & 8'hdf;
    high_drive = rnd();
    want((low_drive & 8'hf4) | 8'h08, 8'hff);
    want((high_drive & ~m) | (v & m), 8'hff);
    cmd('{OP_GET_LOW});
    cmd('{OP_GET_HIGH});
    settle();
    // every tms opcode, idle level matched to its change edge
    cmd('{OP_LOOP_ON});
    foreach (ops[i]) begin
      idle = (i >= 3);
      cmd('{OP_SET_LOW, {7'h04, idle}, 8'h0b});
      settle();
      d = rnd();
      ln = rnd() & 8'h07;
      nbits = 0;
      nonidle = 0;
      if (ops[i][OPB_READ]) want({8{d[7]}}, 8'hff << (7 - ln));
      cmd('{ops[i], ln, d});
      settle();
      chk8("bit count", ln + 8'h01, 8'(nbits));
      chk8("tms", d & (8'hff >> (7 - ln)), tms_seq >> (7 - ln));
      chk8("clk high", ln + 8'h01, 8'(nonidle));
      chk8("clk idle", {7'h00, idle}, {7'h00, low_out[PIN_CLK]});
    end
    // divisor, with and without the divide-by-5 stage
    cmd('{OP_LOOP_OFF});
    idle = 1'b0;
    cmd('{OP_SET_LOW, 8'h08, 8'h0b});
    cmd('{OP_SET_DIV, 8'h02, 8'h00});
    low_drive = 8'h04;
    for (int k = 0; k < 2; k++) begin
      div5 = k[0];
      settle();
      d = 8'h00;
      nonidle = 0;
      want(8'hff, 8'hc0);
      cmd('{OP_TMSR_FR, 8'h01, d});
      settle();
      chk8("half period", k ? 8'd30 : 8'd6, 8'(nonidle));
    end
    cmd('{OP_FLUSH});
    settle();
    chk8("flush", 8'h01, 8'(flushes));
    // replies held back by the host keep their order
    // clock, data out and tms all left low by the last shift
    rsp_ready = 1'b0;
    want(8'h04, 8'hff);
    want((high_drive & ~m) | (v & m), 8'hff);
    want(8'h04, 8'hff);
    cmd('{OP_GET_LOW});
    cmd('{OP_GET_HIGH});
    cmd('{OP_GET_LOW});
    repeat (20) @(posedge clock);
    #1;
    chk8("stalled", 8'h00, {7'h00, cmd_ready});
    rsp_ready = 1'b1;
    settle();
    // cpu bus writes then reads back
    cpu_mode = 1'b1;
    a = rnd();
    h = rnd();
    w = rnd();
    v = rnd();
    cmd('{OP_BUS_WE, h, a, w});
    cmd('{OP_BUS_WS, a ^ 8'h01, v});
    want(v, 8'hff);
    cmd('{OP_BUS_RS, a ^ 8'h01});
    want(w, 8'hff);
    cmd('{OP_BUS_RE, h, a});
    settle();
    // waits on the aux line and on the low group line
    aux = 2'b01;
    cmd('{OP_WAIT_LO});
    repeat (30) @(posedge clock);
    #1;
    chk8("wait low", 8'h00, {7'h00, cmd_ready});
    aux = 2'b00;
    settle();
    cpu_mode = 1'b0;
    cmd('{OP_WAIT_HI});
    repeat (30) @(posedge clock);
    #1;
    chk8("wait high", 8'h00, {7'h00, cmd_ready});
    en = 1'b0;
    @(posedge clock);
    #1;
    en = 1'b1;
    settle();
    low_drive = 8'h24;
    want(8'h24, 8'hff);
    cmd('{OP_WAIT_HI});
    cmd('{OP_GET_LOW});
    settle();
    summarize();
  end
endmodule
